// *** logic/gauge_defs.svh ***
/*
  Register offsets, reset values and timing counts of the gauge measure and mode control block.
  Assumes a 25 MHz clock and an APB bus with byte addresses in the low eight bits.
*/
`ifndef GAUGE_DEFS_SVH
`define GAUGE_DEFS_SVH
`define OFF_MODE 8'h00
`define OFF_SLEEP 8'h04
`define OFF_TEMP_EN 8'h08
`define OFF_BAL_CFG 8'h0C
`define OFF_CELL_CFG 8'h10
`define OFF_SER_CFG2 8'h14
`define OFF_VENDOR 8'h18
`define OFF_ACCESS 8'h1C
`define OFF_CELL_CAL 8'h20
`define OFF_SOV_THR 8'h24
`define OFF_TEMP_LIM 8'h28
`define OFF_FLT_DLY 8'h2C
`define OFF_STATUS 8'h30
`define OFF_CHARGE 8'h34
`define OFF_LOG_T 8'h38
`define OFF_LOG_V 8'h3C
`define OFF_LOG_I 8'h40
`define OFF_SENSE_OFS 8'h44
`define OFF_BOUND 8'h50
`define OFF_TARGET 8'h70
`define NUM_BOUNDS 5
`define NUM_RANGES 6
`define RST_SLEEP_INTV 8'h14
`define RST_TEMP_EN 2'h3
`define RST_BAL_CFG 1'h0
`define RST_CELL_CFG 1'h1
`define RST_SER_CFG2 1'h1
`define RST_CELL_CAL 24'h800000
`define RST_SOV_THR 16'h1194
`define RST_TEMP_LIM 32'h0D5C0AAB
`define RST_FLT_DLY 16'h0202
`define RST_LOG_MAX 16'h0000
`define RST_LOG_MIN 16'hFFFF
`define VENDOR_CAL_A 16'hF081
`define VENDOR_CAL_B 16'hF082
`define CELL_GAIN_SHIFT 7
`define STATUS_REFUSED_BIT 3
`define SENSE_FULL_MV 100
`define COULOMB_LSB_PVH 650
`define CLK_HZ 25000000
`define PASS_MS 250
`define IDLE_S 5
`define PASS_CYCLES (`PASS_MS * (`CLK_HZ / 1000))
`define IDLE_CYCLES (`IDLE_S * `CLK_HZ)
`endif

// *** logic/gauge_pkg.sv ***
/*
  Types of the gauge measure and mode control block.
  Assumes the constants of gauge_defs.svh.
*/
package gauge_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MEAS = 5'h02,
    ST_CALC = 5'h04,
    ST_ACAL = 5'h08,
    ST_OFF = 5'h10
  } state_type;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_SHUT = 2'h2
  } mode_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [15:0] cell0;
    logic [15:0] cell1;
    logic [15:0] intTemp;
    logic [15:0] extTemp;
    logic signed [15:0] sense;
  } sample_type;
  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] current;
  } report_type;
endpackage : gauge_pkg

// *** logic/gauge_measure_mode_control.sv ***
/*
  Measurement scheduling, operating mode, charge counting, calibration, access control,
  lifetime logging and charger reporting of a 1- to 2-series cell battery gauge.
  Assumes synchronous ADC samples, an external SHA-1 responder that reports authOk,
  and the two serial bus line levels already sampled on this clock.
*/
// The address map and the APB interface to the registers were left to the implementer.
// Behaviour
// - Normal mode: one pass every 250 ms.
// - Sleep mode: pass at programmable interval.
// - Shutdown stops all measuring and reporting.
// - Unseal or full access needs authentication.
// - Sense input signed, plus/minus 100 mV.
// - Positive count means charge, negative discharge.
// - Continuous charge accumulator, 0.65 nVh step.
// - Cells sampled per pass, scaled, offset corrected.
// - Charge or discharge from sense sign.
// - Offset calibration after 5 s bus idle.
// - Internal and external temperature enabled separately.
// - Temperature enable: bit0 internal, bit1 external.
// - Vendor codes F081/F082 enter calibration.
// - Charger report only when bit0 set.
// - Targets chosen by active temperature range.
// - Inhibit charge outside allowed temperature.
// - Separate charge and discharge alarms.
// - Lifetime extremes of temperature, current, voltage.
// - Cell config bit0 selects two series.
// - Balancing config bit0 clear disables balancing.
// - Safety overvoltage past delay shuts down.
// - Each fault has its own delay.
// - Both bus lines low: calibrate, sleep.
// - Device sends charger targets itself.
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_measure_mode_control #(
  parameter logic [31:0] PASS_CYCLES = `PASS_CYCLES,
  parameter logic [31:0] IDLE_CYCLES = `IDLE_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // APB slave.
  input wire gauge_pkg::apb_req_type apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement front end and authentication result.
  input wire gauge_pkg::sample_type samples,
  input wire logic authOk,
  // Serial bus line levels.
  input wire logic busClkIn,
  input wire logic busDataIn,
  // Mode and measurement status.
  output gauge_pkg::mode_type opMode,
  output logic passStrobe,
  output logic chargingFlag,
  output logic dischargingFlag,
  // Configuration to the analog side.
  output logic internalTempEnable,
  output logic externalThermistorEnable,
  output logic balanceEnable,
  output logic seriesCellCountSelect,
  // Protection and charger reporting.
  output logic chargeInhibit,
  output logic chargeAlarm,
  output logic dischargeAlarm,
  output logic safetyOvervoltageFault,
  output gauge_pkg::report_type report,
  output logic reportValid
);
  import gauge_pkg::*;

  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction : max16

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction : min16

  state_type state_reg, state_next;
  mode_type mode_reg, mode_next;
  logic ready_reg, slverr_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] sleepIntv_reg, sleepCnt_reg;
  logic [1:0] tempEn_reg;
  logic balCfg_reg, cellCfg_reg, serCfg2_reg, calMode_reg, refused_reg;
  logic [1:0] access_reg;
  logic [23:0] cellCal_reg;
  logic [15:0] sovThr_reg, fltDly_reg;
  logic [31:0] tempLim_reg;
  logic signed [15:0] senseOfs_reg;
  logic [15:0] bound_reg [`NUM_BOUNDS];
  logic [31:0] target_reg [`NUM_RANGES];
  logic [31:0] tick_reg, idleCnt_reg;
  logic signed [31:0] accum_reg;
  sample_type sample_reg;
  logic [1:0] lines_reg;
  logic lowPrev_reg, acalReq_reg, lowPend_reg;
  logic [7:0] fltCnt_reg [2];
  logic [1:0] fault_reg;
  logic [15:0] maxT_reg, minT_reg, maxV_reg, minV_reg, maxI_reg;
  logic pass_reg, chg_reg, dsg_reg, alarmC_reg, alarmD_reg, rptValid_reg;
  report_type report_reg;

  // Bus decode.
  wire logic apbSetup = apbReq.psel & apbReq.penable & ~ready_reg;
  wire logic apbDone = apbReq.psel & apbReq.penable & ready_reg;
  wire logic [7:0] addr = apbReq.paddr;
  wire logic [31:0] wd = apbReq.pwdata;
  wire logic inBound = (addr >= `OFF_BOUND) && (addr < 8'(`OFF_BOUND + 4 * `NUM_BOUNDS));
  wire logic inTarget = (addr >= `OFF_TARGET) && (addr < 8'(`OFF_TARGET + 4 * `NUM_RANGES));
  wire logic tblHit = (inBound | inTarget) & (addr[1:0] == 2'h0);
  wire logic [2:0] tblIdx = inBound ? 3'((addr - `OFF_BOUND) >> 2) : 3'((addr - `OFF_TARGET) >> 2);
  wire logic regHit = (addr <= `OFF_SENSE_OFS) && (addr[1:0] == 2'h0);
  wire logic mapped = regHit | tblHit;
  wire logic wrEn = apbDone & apbReq.pwrite & mapped;
  wire logic wrMode = wrEn & (addr == `OFF_MODE);
  wire logic wrAccess = wrEn & (addr == `OFF_ACCESS);
  wire logic wrVendor = wrEn & (addr == `OFF_VENDOR);
  wire logic wrStatus = wrEn & (addr == `OFF_STATUS);
  wire logic levelUp = wd[1:0] > access_reg;
  wire logic calCode = (wd[15:0] == `VENDOR_CAL_A) | (wd[15:0] == `VENDOR_CAL_B);

  // Sense path, offset removed, sign carried into the charge count.
  // signed differential sense.
  wire logic signed [16:0] senseCal = 17'(samples.sense) - 17'(senseOfs_reg);
  wire logic signed [16:0] sensePass = 17'(sample_reg.sense) - 17'(senseOfs_reg);
  wire logic [15:0] curMag = sensePass[16] ? 16'(-sensePass) : 16'(sensePass);

  // Cell readings, scaled then offset corrected.
  wire logic [31:0] prod0 = 32'(sample_reg.cell0) * 32'(cellCal_reg[23:16]);
  wire logic [31:0] prod1 = 32'(sample_reg.cell1) * 32'(cellCal_reg[23:16]);
  wire logic [15:0] cellV0 = 16'(prod0 >> `CELL_GAIN_SHIFT) - cellCal_reg[15:0];
  wire logic [15:0] cellV1 = 16'(prod1 >> `CELL_GAIN_SHIFT) - cellCal_reg[15:0];
  wire logic [15:0] cellMax = cellCfg_reg ? max16(cellV0, cellV1) : cellV0;
  wire logic [15:0] cellMin = cellCfg_reg ? min16(cellV0, cellV1) : cellV0;

  // Pack temperature: the thermistor when enabled, else the on-die sensor.
  wire logic tempValid = |tempEn_reg;
  wire logic [15:0] tempNow = tempEn_reg[1] ? sample_reg.extTemp : sample_reg.intTemp;
  wire logic tempOut = tempValid & ((tempNow < tempLim_reg[15:0]) | (tempNow > tempLim_reg[31:16]));
  logic [2:0] rangeIdx;

  always_comb begin
    rangeIdx = 3'h0;
    for (int i = 0; i < `NUM_BOUNDS; i++) begin
      if (tempNow > bound_reg[i]) begin
        rangeIdx = 3'(i + 1);
      end
    end
  end

  // Scheduling: a fixed pass tick, divided further in sleep mode.
  wire logic tick = (tick_reg == PASS_CYCLES - 32'h1);
  wire logic sleepDue = (sleepCnt_reg + 8'h1 >= sleepIntv_reg);
  wire logic startPass = tick & ((mode_reg == MODE_NORMAL) | ((mode_reg == MODE_SLEEP) & sleepDue));
  wire logic lineChange = ({busClkIn, busDataIn} != lines_reg);
  wire logic bothLow = ~busClkIn & ~busDataIn;
  wire logic idleHit = ~lineChange & (idleCnt_reg == IDLE_CYCLES - 32'h1);
  wire logic [1:0] fltCond = {tempOut, cellMax > sovThr_reg};
  wire logic [7:0] fltDly [2] = '{fltDly_reg[7:0], fltDly_reg[15:8]};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (mode_reg != MODE_SHUT) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (mode_reg == MODE_SHUT) begin
          state_next = ST_OFF;
        end else if (startPass) begin
          state_next = ST_MEAS;
        end else if (acalReq_reg) begin
          state_next = ST_ACAL;
        end
      end
      ST_MEAS: state_next = ST_CALC;
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    mode_next = mode_reg;
    if (wrMode && wd[1:0] <= 2'(MODE_SHUT)) begin
      mode_next = mode_type'(wd[1:0]);
    end
    if (state_reg == ST_ACAL && lowPend_reg) begin
      mode_next = MODE_SLEEP;
    end
    if (fault_reg[0]) begin
      mode_next = MODE_SHUT;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    case (addr)
      `OFF_MODE: rdata_next = 32'(mode_reg);
      `OFF_SLEEP: rdata_next = 32'(sleepIntv_reg);
      `OFF_TEMP_EN: rdata_next = 32'(tempEn_reg);
      `OFF_BAL_CFG: rdata_next = 32'(balCfg_reg);
      `OFF_CELL_CFG: rdata_next = 32'(cellCfg_reg);
      `OFF_SER_CFG2: rdata_next = 32'(serCfg2_reg);
      `OFF_ACCESS: rdata_next = 32'(access_reg);
      `OFF_CELL_CAL: rdata_next = 32'(cellCal_reg);
      `OFF_SOV_THR: rdata_next = 32'(sovThr_reg);
      `OFF_TEMP_LIM: rdata_next = tempLim_reg;
      `OFF_FLT_DLY: rdata_next = 32'(fltDly_reg);
      `OFF_STATUS: rdata_next = {16'h0, 2'h0, state_reg, access_reg, chargeInhibit, fault_reg,
        refused_reg, calMode_reg, dsg_reg, chg_reg};
      `OFF_CHARGE: rdata_next = accum_reg;
      `OFF_LOG_T: rdata_next = {maxT_reg, minT_reg};
      `OFF_LOG_V: rdata_next = {maxV_reg, minV_reg};
      `OFF_LOG_I: rdata_next = 32'(maxI_reg);
      `OFF_SENSE_OFS: rdata_next = {16'h0, senseOfs_reg};
      default: begin
        if (tblHit && inBound) begin
          rdata_next = 32'(bound_reg[tblIdx]);
        end else if (tblHit) begin
          rdata_next = target_reg[tblIdx];
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ready_reg <= apbSetup;
      slverr_reg <= apbSetup & ~mapped;
      rdata_reg <= apbSetup ? rdata_next : 32'h0;
    end
  end

  // Software configuration; calibration words only in calibration mode.
  always_ff @(posedge clock) begin
    if (srst) begin
      sleepIntv_reg <= `RST_SLEEP_INTV;
      tempEn_reg <= `RST_TEMP_EN;
      balCfg_reg <= `RST_BAL_CFG;
      cellCfg_reg <= `RST_CELL_CFG;
      serCfg2_reg <= `RST_SER_CFG2;
      sovThr_reg <= `RST_SOV_THR;
      tempLim_reg <= `RST_TEMP_LIM;
      fltDly_reg <= `RST_FLT_DLY;
      cellCal_reg <= `RST_CELL_CAL;
    end else if (wrEn) begin
      case (addr)
        `OFF_SLEEP: sleepIntv_reg <= wd[7:0];
        `OFF_TEMP_EN: tempEn_reg <= wd[1:0];
        `OFF_BAL_CFG: balCfg_reg <= wd[0];
        `OFF_CELL_CFG: cellCfg_reg <= wd[0];
        `OFF_SER_CFG2: serCfg2_reg <= wd[0];
        `OFF_SOV_THR: sovThr_reg <= wd[15:0];
        `OFF_TEMP_LIM: tempLim_reg <= wd;
        `OFF_FLT_DLY: fltDly_reg <= wd[15:0];
        `OFF_CELL_CAL: cellCal_reg <= calMode_reg ? wd[23:0] : cellCal_reg;
        default: sleepIntv_reg <= sleepIntv_reg;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < `NUM_RANGES; g++) begin : gTarget
      always_ff @(posedge clock) begin
        if (srst) begin
          target_reg[g] <= 32'h0;
        end else if (wrEn && inTarget && tblIdx == 3'(g)) begin
          target_reg[g] <= wd;
        end
      end
    end
    for (genvar g = 0; g < `NUM_BOUNDS; g++) begin : gBound
      always_ff @(posedge clock) begin
        if (srst) begin
          bound_reg[g] <= 16'h0;
        end else if (wrEn && inBound && tblIdx == 3'(g)) begin
          bound_reg[g] <= wd[15:0];
        end
      end
    end
    for (genvar g = 0; g < 2; g++) begin : gFault
      always_ff @(posedge clock) begin
        if (srst) begin
          fltCnt_reg[g] <= 8'h0;
          fault_reg[g] <= 1'b0;
        end else if (state_reg == ST_CALC) begin
          fltCnt_reg[g] <= ~fltCond[g] ? 8'h0 : (&fltCnt_reg[g] ? fltCnt_reg[g] : fltCnt_reg[g] + 8'h1);
          fault_reg[g] <= (fltCond[g] & (fltCnt_reg[g] >= fltDly[g])) | ((g == 0) & fault_reg[g]);
        end
      end
    end
  endgenerate

  // Access, calibration entry and the refusal flag.
  always_ff @(posedge clock) begin
    if (srst) begin
      access_reg <= 2'h0;
      calMode_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (wrAccess && (!levelUp || authOk)) begin
        access_reg <= wd[1:0];
      end
      if (wrVendor) begin
        calMode_reg <= calCode;
      end
      if (wrAccess && levelUp && !authOk) begin
        refused_reg <= 1'b1;
      end else if (wrStatus && wd[`STATUS_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_NORMAL;
      tick_reg <= 32'h0;
      sleepCnt_reg <= 8'h0;
      idleCnt_reg <= 32'h0;
      lines_reg <= 2'h3;
      lowPrev_reg <= 1'b0;
      acalReq_reg <= 1'b0;
      lowPend_reg <= 1'b0;
      senseOfs_reg <= 16'h0;
      accum_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
      if (tick) begin
        sleepCnt_reg <= (startPass || mode_reg != MODE_SLEEP) ? 8'h0 : sleepCnt_reg + 8'h1;
      end
      lines_reg <= {busClkIn, busDataIn};
      lowPrev_reg <= bothLow;
      idleCnt_reg <= (lineChange || idleHit) ? 32'h0 : idleCnt_reg + 32'h1;
      if (idleHit || (bothLow && !lowPrev_reg)) begin
        acalReq_reg <= 1'b1;
      end else if (state_reg == ST_ACAL) begin
        acalReq_reg <= 1'b0;
      end
      if (bothLow && !lowPrev_reg) begin
        lowPend_reg <= 1'b1;
      end else if (state_reg == ST_ACAL) begin
        lowPend_reg <= 1'b0;
      end
      if (state_reg == ST_ACAL) begin
        senseOfs_reg <= samples.sense;
      end
      if (state_reg != ST_OFF) begin
        accum_reg <= accum_reg + 32'(senseCal);
      end
    end
  end

  // Per-pass sampling, logging and reporting.
  always_ff @(posedge clock) begin
    if (srst) begin
      sample_reg <= '0;
      pass_reg <= 1'b0;
      chg_reg <= 1'b0;
      dsg_reg <= 1'b0;
      maxT_reg <= `RST_LOG_MAX;
      minT_reg <= `RST_LOG_MIN;
      maxV_reg <= `RST_LOG_MAX;
      minV_reg <= `RST_LOG_MIN;
      maxI_reg <= `RST_LOG_MAX;
      alarmC_reg <= 1'b0;
      alarmD_reg <= 1'b0;
      report_reg <= '0;
      rptValid_reg <= 1'b0;
    end else begin
      pass_reg <= (state_reg == ST_MEAS);
      rptValid_reg <= 1'b0;
      if (state_reg == ST_MEAS) begin
        sample_reg <= samples;
      end
      if (state_reg == ST_CALC) begin
        chg_reg <= (sensePass > 0);
        dsg_reg <= (sensePass < 0);
        maxV_reg <= max16(maxV_reg, cellMax);
        minV_reg <= min16(minV_reg, cellMin);
        maxI_reg <= max16(maxI_reg, curMag);
        if (tempValid) begin
          maxT_reg <= max16(maxT_reg, tempNow);
          minT_reg <= min16(minT_reg, tempNow);
        end
        alarmC_reg <= fault_reg[1] | fault_reg[0];
        alarmD_reg <= fault_reg[0];
        rptValid_reg <= serCfg2_reg;
        report_reg.voltage <= target_reg[rangeIdx][15:0];
        report_reg.current <= fault_reg[1] ? 16'h0 : target_reg[rangeIdx][31:16];
      end
    end
  end

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = slverr_reg;
  assign opMode = mode_reg;
  assign passStrobe = pass_reg;
  assign chargingFlag = chg_reg;
  assign dischargingFlag = dsg_reg;
  // each sensor has its own enable.
  assign internalTempEnable = tempEn_reg[0];
  assign externalThermistorEnable = tempEn_reg[1];
  assign balanceEnable = balCfg_reg;
  assign seriesCellCountSelect = cellCfg_reg;
  assign chargeInhibit = fault_reg[1];
  assign chargeAlarm = alarmC_reg;
  assign dischargeAlarm = alarmD_reg;
  assign safetyOvervoltageFault = fault_reg[0];
  // the block drives the charger report.
  assign report = report_reg;
  assign reportValid = rptValid_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence passSteps;
    state_reg == ST_MEAS ##1 state_reg == ST_CALC ##1 state_reg == ST_IDLE;
  endsequence

  chk_pass_steps: assert property (
    state_reg == ST_IDLE && startPass && mode_reg != MODE_SHUT |=> passSteps ##0 passStrobe == 1'b0)
    else $error("pass did not run measure then calc");
  chk_shutdown_quiet: assert property (
    state_reg == ST_OFF |=> $stable(accum_reg) && !passStrobe)
    else $error("activity while shut down");
  chk_charge_count: assert property (
    state_reg != ST_OFF |=> accum_reg == $past(accum_reg) + 32'($past(senseCal)))
    else $error("charge count did not add signed sense");
  chk_sign_flag: assert property (
    state_reg == ST_CALC |=> chargingFlag == ($past(sensePass) > 0) && dischargingFlag == ($past(sensePass) < 0))
    else $error("charge direction flag wrong");
  chk_idle_cal: assert property (
    $rose(state_reg == ST_ACAL) |-> $past(acalReq_reg))
    else $error("calibration without idle bus");
  chk_auth_gate: assert property (
    wrAccess && levelUp && !authOk |=> $stable(access_reg) && refused_reg)
    else $error("access raised without authentication");
  chk_cal_entry: assert property (
    wrVendor && calCode |=> calMode_reg ##1 (calMode_reg || $past(wrVendor)))
    else $error("vendor code did not enter calibration");
  chk_report_gate: assert property (
    reportValid |-> $past(serCfg2_reg) && $past(state_reg == ST_CALC))
    else $error("report sent while disabled");
  chk_sov_shutdown: assert property (
    $rose(safetyOvervoltageFault) |=> mode_reg == MODE_SHUT ##1 state_reg == ST_OFF || state_reg != ST_IDLE)
    else $error("overvoltage did not shut down");
endmodule : gauge_measure_mode_control

// *** testbench/bus_host_model.sv ***
/*
  Host on the two-wire bus: serial line levels and the authentication result.
  Assumes the clock of the block under test and a bench that sets activity.
*/
`timescale 1ns/1ps
module bus_host_model (
  // Clock and control from the bench.
  input wire logic clock,
  input wire logic active,
  input wire logic pulledLow,
  input wire logic authed,
  // Lines seen by the block.
  output logic busClk,
  output logic busData,
  output logic authOk
);
  initial busClk = 1'b1;
  always @(posedge clock) busClk <= pulledLow ? 1'b0 : (active ? ~busClk : 1'b1);
  // Data idles high and drops only while the lines are pulled low.
  assign busData = ~pulledLow;
  assign authOk = authed;
endmodule : bus_host_model

// *** testbench/testbench.sv ***
/*
  Self-checking bench of the gauge measure and mode control block over APB.
  Assumes short pass and idle counts handed in as parameters.
*/
`timescale 1ns/1ps
`include "gauge_defs.svh"
module testbench;
  import gauge_pkg::*;
  localparam int PC = 40;
  logic clock, srst, authed, active, busClk, busData, authOk, pready, pslverr, rptValid, strobe;
  logic chg, dsg, intEn, extEn, low, sovFlt;
  logic [31:0] prdata, t, rptExp;
  logic [15:0] r;
  logic [15:0] codes [3] = '{`VENDOR_CAL_A, 16'h0001, `VENDOR_CAL_B};
  apb_req_type apbReq;
  sample_type samples;
  mode_type opMode;
  report_type rpt;
  logic [64:0] notes [$];
  int bad_count, cmp_count, n, rptCount;
  bus_host_model host (.clock(clock), .active(active), .pulledLow(low), .authed(authed), .busClk(busClk),
    .busData(busData), .authOk(authOk));
  gauge_measure_mode_control #(.PASS_CYCLES(PC), .IDLE_CYCLES(100)) dut (.clock(clock), .srst(srst),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .samples(samples), .authOk(authOk),
    .busClkIn(busClk), .busDataIn(busData), .opMode(opMode), .passStrobe(strobe), .chargingFlag(chg),
    .dischargingFlag(dsg), .internalTempEnable(intEn), .externalThermistorEnable(extEn), .balanceEnable(),
    .seriesCellCountSelect(), .chargeInhibit(), .chargeAlarm(), .dischargeAlarm(),
    .safetyOvervoltageFault(sovFlt), .report(rpt), .reportValid(rptValid));
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d.", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  // One APB transfer; reads leave {error, mask, data} for the monitor.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m, e, input logic err);
    int k;
    if (!wr) notes.push_back({err, m, e});
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1);
    cmp("access cycles", 32'h2, k);
    apbReq <= '0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask : rd
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge clock);
      g++;
    end while (strobe !== 1'b1 && g < 300);
  endtask : gap
  always @(posedge clock) begin
    if (pready === 1'b1 && apbReq.pwrite === 1'b0) begin
      cmp("prdata", notes[0][31:0], prdata & notes[0][63:32]);
      cmp("pslverr", {31'h0, notes[0][64]}, {31'h0, pslverr});
      void'(notes.pop_front());
    end
    if (rptValid === 1'b1) begin
      rptCount++;
      cmp("report", rptExp, rpt);
    end
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(40 * 20000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hBBBA9767));
    srst = 1'b1;
    apbReq = '0;
    authed = 1'b0;
    active = 1'b1;
    low = 1'b0;
    rptExp = '0;
    samples = '{16'h0F00, 16'h0F00, 16'h0C00, 16'h0C00, 16'sh0000};
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(`OFF_TEMP_EN, '1, `RST_TEMP_EN);
    rd(`OFF_SLEEP, '1, `RST_SLEEP_INTV);
    rd(`OFF_SOV_THR, '1, `RST_SOV_THR);
    apb(1'b0, 8'h48, 32'h0, '1, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_TEMP_EN, i);
      cmp("internal enable", i & 1, intEn);
      cmp("external enable", i >> 1, extEn);
    end
    foreach (codes[j]) begin
      wr(`OFF_VENDOR, codes[j]);
      rd(`OFF_STATUS, 32'h4, {29'h0, codes[j][15], 2'h0});
    end
    wr(`OFF_ACCESS, 32'h2);
    rd(`OFF_STATUS, 32'h188, 32'h8);
    authed <= 1'b1;
    wr(`OFF_ACCESS, 32'h2);
    rd(`OFF_ACCESS, '1, 32'h2);
    gap(n);
    gap(n);
    cmp("normal gap", PC, n);
    for (int s = 0; s < 2; s++) begin
      r = 16'($urandom_range(1, 32767));
      samples.sense <= s ? -r : r;
      gap(n);
      gap(n);
      @(posedge clock);
      cmp("charging", 1 - s, chg);
      cmp("discharging", s, dsg);
    end
    // Temperature lies above bounds 0 to 3 only, so range 4 is active.
    gap(n);
    wr(8'h60, 32'hFFFF);
    t = $urandom();
    wr(8'h84, ~t);
    wr(8'h80, t);
    rptExp = {t[15:0], t[31:16]};
    rptCount = 0;
    gap(n);
    gap(n);
    cmp("report seen", 32'h1, {31'h0, rptCount != 0});
    wr(`OFF_SER_CFG2, 32'h0);
    gap(n);
    rptCount = 0;
    gap(n);
    gap(n);
    cmp("report count", 32'h0, rptCount);
    wr(`OFF_SLEEP, 32'h3);
    low <= 1'b1;
    repeat (10) @(posedge clock);
    cmp("low lines mode", MODE_SLEEP, opMode);
    low <= 1'b0;
    wr(`OFF_MODE, 32'h1);
    gap(n);
    gap(n);
    cmp("sleep gap", 3 * PC, n);
    r = 16'($urandom_range(1, 32767));
    samples.sense <= r;
    active <= 1'b0;
    repeat (300) @(posedge clock);
    rd(`OFF_SENSE_OFS, '1, {16'h0, r});
    active <= 1'b1;
    gap(n);
    wr(`OFF_MODE, 32'h2);
    cmp("mode", MODE_SHUT, opMode);
    gap(n);
    cmp("shutdown gap", 300, n);
    wr(`OFF_SOV_THR, 32'h1);
    wr(`OFF_MODE, 32'h0);
    repeat (200) @(posedge clock);
    wr(`OFF_MODE, 32'h0);
    cmp("overvoltage fault", 32'h1, {31'h0, sovFlt});
    cmp("overvoltage mode", MODE_SHUT, opMode);
    report_and_stop();
  end
endmodule : testbench
